// *** common/upb_pkg.sv ***
// constants, types and helpers for the parity, break and ninth-bit serial block
// assumes one 25 MHz clock and a synchronous active-high reset in every user
// Function
// RULE1 - parity enable adds and checks parity bit
// RULE2 - selector 00 even, 01 odd
// RULE3 - selector 10 forces one, 11 forces zero
// RULE4 - break bit set sends logic zero
// RULE5 - finish buffered data, then low thirteen bits
// RULE6 - break bit clear means normal transmit line
// RULE7 - ninth received bit kept in status bit
// RULE8 - written ninth bit sent as ninth data
// RULE9 - word length picks eight or nine bits
// RULE10 - word length zero eight, one nine
// RULE11 - parity takes last data slot, not stored
// RULE12 - parity mismatch sets parity error flag
// RULE13 - unit disable clears break bit and flags
// RULE14 - even/odd make total ones count even/odd
// RULE15 - receiver checks all four parity types
package upb_pkg;
	localparam int unsigned CLK_HZ   = 25_000_000;            // system clock rate
	localparam int unsigned BAUD_DEF = 115_200;               // default line rate
	localparam int unsigned BIT_CLKS = CLK_HZ / BAUD_DEF;     // clocks per bit
	localparam logic [1:0]  PAR_EVEN  = 2'h0;                 // parity selector codes
	localparam logic [1:0]  PAR_ODD   = 2'h1;
	localparam logic [1:0]  PAR_MARK  = 2'h2;
	localparam logic [1:0]  PAR_SPACE = 2'h3;
	localparam logic [3:0]  SLOTS_8   = 4'h8;                 // data slots, short word
	localparam logic [3:0]  SLOTS_9   = 4'h9;                 // data slots, long word
	localparam logic [3:0]  BREAK_LEN = 4'hd;                 // least break, in bits
	localparam int unsigned NINTH_POS = 8;                    // ninth bit index
	localparam int unsigned BIT7_POS  = 7;                    // data bit seven index

	// transmit sequencer states
	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b010,
		TX_STOP  = 3'b011,
		TX_BREAK = 3'b100
	} upb_tx_state_e;

	// receive sequencer states
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} upb_rx_state_e;

	// parity slot value from selector and odd-ones flag of payload
	function automatic logic upb_parity(input logic [1:0] sel, input logic ones_odd);
		case (sel)
			PAR_EVEN: upb_parity = ones_odd;      // total count even
			PAR_ODD:  upb_parity = ~ones_odd;     // total count odd
			PAR_MARK: upb_parity = 1'b1;          // forced one
			default:  upb_parity = 1'b0;          // forced zero
		endcase
	endfunction

	// mask of the low n bits of a nine-bit frame
	function automatic logic [8:0] upb_mask(input logic [3:0] n);
		upb_mask = 9'h000;
		for (int i = 0; i < 9; i++) begin
			if (4'(i) < n) begin
				upb_mask[i] = 1'b1;
			end
		end
	endfunction
endpackage

// *** verilog/upb_bit_tick.sv ***
// bit-period enable divider, reloadable to align with a start edge
// assumes synchronous reset and one clock; tick is a one-cycle enable
`timescale 1ns/1ns
module upb_bit_tick #(
	parameter int unsigned DIV = upb_pkg::BIT_CLKS          // clocks per bit
) (
	input  wire logic        clk_i,      // system clock
	input  wire logic        reset_i,    // synchronous reset
	input  wire logic        run_i,      // counting allowed
	input  wire logic        load_i,     // reload the count
	input  wire logic [15:0] load_val_i, // value to reload
	output logic             tick_o      // one-cycle bit enable
);
	logic [15:0] count_q;                // cycles to next tick

	// down counter wrapping every DIV cycles
	always_ff @(posedge clk_i) begin
		if (reset_i || !run_i) begin
			count_q <= 16'h0000;
		end else if (load_i) begin
			count_q <= load_val_i;
		end else if (count_q == 16'h0000) begin
			count_q <= 16'(DIV - 1);
		end else begin
			count_q <= count_q - 16'h0001;
		end
	end

	assign tick_o = run_i && !load_i && (count_q == 16'h0000);
endmodule // upb_bit_tick

// *** verilog/upb_uart.sv ***
// frame format core: parity, break, ninth bit, one-word transmit buffer
// assumes serial_rx_i already synchronous; control bits arrive as plain ports
`timescale 1ns/1ns
module upb_uart #(
	parameter int unsigned DIV = upb_pkg::BIT_CLKS           // clocks per bit
) (
	input  wire logic       clk_i,                 // system clock
	input  wire logic       reset_i,               // synchronous reset
	input  wire logic       serial_unit_enable_i,  // whole unit on
	input  wire logic       word_length_select_i,  // 0 eight, 1 nine slots
	input  wire logic       parity_enable_bit_i,   // parity slot in use
	input  wire logic [1:0] parity_type_select_i,  // even, odd, mark, space
	input  wire logic       break_wr_i,            // write strobe of break bit
	input  wire logic       break_wdata_i,         // value written to break bit
	output logic            break_send_bit_o,      // break bit readback
	input  wire logic       tx_valid_i,            // transmit word offered
	input  wire logic [7:0] tx_data_i,             // transmit data byte
	input  wire logic       transmit_ninth_bit_i,  // ninth bit, taken with word
	output logic            tx_ready_o,            // buffer can take a word
	output logic            tx_idle_o,             // nothing queued or sending
	output logic            serial_tx_o,           // transmit line
	input  wire logic       serial_rx_i,           // receive line
	output logic            rx_valid_o,            // one-cycle word pulse
	output logic [7:0]      rx_data_o,             // received data byte
	output logic            received_ninth_bit_o,  // ninth received bit
	output logic            parity_error_flag_o,   // sticky parity error
	input  wire logic       parity_error_flag_clear_i           // clears parity error
);
	upb_pkg::upb_tx_state_e tx_state_q;    // transmit sequencer
	upb_pkg::upb_rx_state_e rx_state_q;    // receive sequencer
	logic       brk_q;                     // break request bit
	logic [7:0] hold_data_q;               // buffered word
	logic       hold_ninth_q;              // buffered ninth bit
	logic       hold_vld_q;                // buffer full
	logic [8:0] tx_shift_q;                // frame being sent
	logic [3:0] tx_slots_q;                // slots of frame being sent
	logic [3:0] tx_idx_q;                  // next slot to drive
	logic [3:0] brk_cnt_q;                 // break bits elapsed, saturating
	logic       tx_q;                      // line register
	logic [8:0] rx_shift_q;                // captured slots
	logic [3:0] rx_idx_q;                  // next slot to sample
	logic [7:0] rx_data_q;                 // delivered byte
	logic       rx_ninth_q;                // delivered ninth bit
	logic       rx_vld_q;                  // delivery pulse
	logic       parity_error_flag_q;                    // parity error flag
	logic       tx_tick;                   // transmit bit enable
	logic       rx_tick;                   // receive sample enable
	logic       rx_load;                   // align receive ticks
	logic [3:0] slots;                     // slots of the selected format
	logic [8:0] tx_frame;                  // frame built from buffer
	logic       rx_done;                   // stop bit sampled
	logic       rx_par_exp;                // expected receive parity
	logic       rx_par_got;                // received parity slot
	logic       en;                        // unit enabled

	assign en    = serial_unit_enable_i;
	assign slots = word_length_select_i ? upb_pkg::SLOTS_9 : upb_pkg::SLOTS_8; // RULE9 RULE10

	// transmit bit timing, free running while enabled
	upb_bit_tick #(.DIV(DIV)) u_tx_tick (
		.clk_i      (clk_i),
		.reset_i    (reset_i),
		.run_i      (en),
		.load_i     (1'b0),
		.load_val_i (16'h0000),
		.tick_o     (tx_tick)
	);

	// receive timing, realigned half a bit after a start edge
	assign rx_load = (rx_state_q == upb_pkg::RX_IDLE) && !serial_rx_i;
	upb_bit_tick #(.DIV(DIV)) u_rx_tick (
		.clk_i      (clk_i),
		.reset_i    (reset_i),
		.run_i      (en),
		.load_i     (rx_load),
		.load_val_i (16'(DIV / 2)),
		.tick_o     (rx_tick)
	);

	// break bit, cleared whenever the unit is off
	always_ff @(posedge clk_i) begin
		if (reset_i || !en) begin
			brk_q <= 1'b0; // RULE13
		end else if (break_wr_i) begin
			brk_q <= break_wdata_i;
		end
	end

	// frame build: payload, ninth bit, parity in the last slot
	always_comb begin
		tx_frame = {hold_ninth_q, hold_data_q}; // RULE8
		if (parity_enable_bit_i) begin
			// parity replaces the last slot
			tx_frame[slots - 4'h1] = upb_pkg::upb_parity(parity_type_select_i,
				^(tx_frame & upb_pkg::upb_mask(slots - 4'h1))); // RULE1 RULE2 RULE3 RULE14
		end
	end

	// one-word transmit buffer
	always_ff @(posedge clk_i) begin
		if (reset_i || !en) begin
			hold_vld_q   <= 1'b0;
			hold_data_q  <= 8'h00;
			hold_ninth_q <= 1'b0;
		end else if (tx_valid_i && tx_ready_o) begin
			hold_vld_q   <= 1'b1;
			hold_data_q  <= tx_data_i;
			hold_ninth_q <= transmit_ninth_bit_i; // RULE8
		end else if (tx_tick && tx_state_q == upb_pkg::TX_IDLE) begin
			hold_vld_q   <= 1'b0; // word moves to the shifter
		end
	end

	// transmit sequencer, all moves on the bit enable
	always_ff @(posedge clk_i) begin
		if (reset_i || !en) begin
			tx_state_q <= upb_pkg::TX_IDLE;
			tx_q       <= 1'b1;
			tx_shift_q <= 9'h000;
			tx_slots_q <= upb_pkg::SLOTS_8;
			tx_idx_q   <= 4'h0;
			brk_cnt_q  <= 4'h0;
		end else if (tx_tick) begin
			case (tx_state_q)
				upb_pkg::TX_IDLE: begin
					if (hold_vld_q) begin
						// buffered data goes out before any break
						tx_shift_q <= tx_frame; // RULE5
						tx_slots_q <= slots;
						tx_q       <= 1'b0;
						tx_state_q <= upb_pkg::TX_START;
					end else if (brk_q) begin
						tx_q       <= 1'b0; // RULE4
						brk_cnt_q  <= 4'h1;
						tx_state_q <= upb_pkg::TX_BREAK;
					end else begin
						tx_q <= 1'b1; // RULE6
					end
				end
				upb_pkg::TX_START: begin
					tx_q       <= tx_shift_q[0];
					tx_idx_q   <= 4'h1;
					tx_state_q <= upb_pkg::TX_DATA;
				end
				upb_pkg::TX_DATA: begin
					if (tx_idx_q == tx_slots_q) begin
						tx_q       <= 1'b1;
						tx_state_q <= upb_pkg::TX_STOP;
					end else begin
						tx_q     <= tx_shift_q[tx_idx_q];
						tx_idx_q <= tx_idx_q + 4'h1;
					end
				end
				upb_pkg::TX_STOP: begin
					tx_state_q <= upb_pkg::TX_IDLE;
				end
				upb_pkg::TX_BREAK: begin
					if (brk_cnt_q < upb_pkg::BREAK_LEN) begin
						brk_cnt_q <= brk_cnt_q + 4'h1; // RULE5
					end else if (!brk_q) begin
						tx_q       <= 1'b1;
						tx_state_q <= upb_pkg::TX_IDLE;
					end
				end
				default: begin
					tx_state_q <= upb_pkg::TX_IDLE;
				end
			endcase
		end
	end

	assign serial_tx_o      = tx_q;
	assign break_send_bit_o = brk_q;
	assign tx_ready_o       = en && !hold_vld_q;
	assign tx_idle_o        = (tx_state_q == upb_pkg::TX_IDLE) && !hold_vld_q && !brk_q;

	// receive sequencer: start check, slot sampling, stop
	always_ff @(posedge clk_i) begin
		if (reset_i || !en) begin
			rx_state_q <= upb_pkg::RX_IDLE;
			rx_shift_q <= 9'h000;
			rx_idx_q   <= 4'h0;
		end else begin
			case (rx_state_q)
				upb_pkg::RX_IDLE: begin
					if (!serial_rx_i) begin
						rx_state_q <= upb_pkg::RX_START;
					end
				end
				upb_pkg::RX_START: begin
					if (rx_tick) begin
						rx_idx_q   <= 4'h0;
						rx_state_q <= serial_rx_i ? upb_pkg::RX_IDLE : upb_pkg::RX_DATA;
					end
				end
				upb_pkg::RX_DATA: begin
					if (rx_tick) begin
						rx_shift_q[rx_idx_q] <= serial_rx_i;
						rx_idx_q             <= rx_idx_q + 4'h1;
						if (rx_idx_q == slots - 4'h1) begin
							rx_state_q <= upb_pkg::RX_STOP;
						end
					end
				end
				upb_pkg::RX_STOP: begin
					if (rx_tick) begin
						rx_state_q <= upb_pkg::RX_IDLE;
					end
				end
				default: begin
					rx_state_q <= upb_pkg::RX_IDLE;
				end
			endcase
		end
	end

	assign rx_done    = (rx_state_q == upb_pkg::RX_STOP) && rx_tick;
	assign rx_par_got = rx_shift_q[slots - 4'h1];
	assign rx_par_exp = upb_pkg::upb_parity(parity_type_select_i,
		^(rx_shift_q & upb_pkg::upb_mask(slots - 4'h1))); // RULE15

	// delivery of byte and ninth bit; parity slot never stored
	always_ff @(posedge clk_i) begin
		if (reset_i || !en) begin
			rx_vld_q   <= 1'b0;
			rx_data_q  <= 8'h00;
			rx_ninth_q <= 1'b0;
		end else begin
			rx_vld_q <= rx_done;
			if (rx_done) begin
				rx_data_q <= rx_shift_q[7:0];
				if (parity_enable_bit_i && !word_length_select_i) begin
					rx_data_q[upb_pkg::BIT7_POS] <= 1'b0; // RULE11
				end
				if (word_length_select_i && !parity_enable_bit_i) begin
					rx_ninth_q <= rx_shift_q[upb_pkg::NINTH_POS]; // RULE7 RULE9
				end
			end
		end
	end

	// sticky parity error, set wins over clear
	always_ff @(posedge clk_i) begin
		if (reset_i || !en) begin
			parity_error_flag_q <= 1'b0; // RULE13
		end else if (rx_done && parity_enable_bit_i && rx_par_got != rx_par_exp) begin
			parity_error_flag_q <= 1'b1; // RULE12
		end else if (parity_error_flag_clear_i) begin
			parity_error_flag_q <= 1'b0;
		end
	end

	assign rx_valid_o           = rx_vld_q;
	assign rx_data_o            = rx_data_q;
	assign received_ninth_bit_o = rx_ninth_q;
	assign parity_error_flag_o  = parity_error_flag_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	chk_break_low: assert property (tx_state_q == upb_pkg::TX_BREAK |-> !serial_tx_o) // RULE4
		else $error("line not low during break");
	chk_break_len: assert property (tx_state_q == upb_pkg::TX_BREAK ##1 tx_state_q != upb_pkg::TX_BREAK && en |-> $past(brk_cnt_q) >= upb_pkg::BREAK_LEN) // RULE5
		else $error("break shorter than thirteen bits");
	chk_break_off: assert property (!en |=> !break_send_bit_o && serial_tx_o) // RULE13
		else $error("disable did not clear break");
	chk_idle_high: assert property (tx_state_q == upb_pkg::TX_IDLE && !brk_q && $past(tx_state_q) == upb_pkg::TX_IDLE && $past(en) |-> serial_tx_o) // RULE6
		else $error("idle line not high");
	chk_par_forced: assert property (tx_state_q == upb_pkg::TX_DATA && tx_tick && parity_enable_bit_i && parity_type_select_i[1] && tx_idx_q == slots - 4'h1 |=> serial_tx_o == !parity_type_select_i[0]) // RULE3
		else $error("forced parity slot wrong");
	chk_par_even: assert property (tx_state_q == upb_pkg::TX_IDLE && tx_tick && hold_vld_q && en && parity_enable_bit_i && parity_type_select_i == upb_pkg::PAR_EVEN |=> !(^(tx_shift_q & upb_pkg::upb_mask(tx_slots_q)))) // RULE2 RULE14
		else $error("even parity frame has odd ones");
	chk_par_odd: assert property (tx_state_q == upb_pkg::TX_IDLE && tx_tick && hold_vld_q && en && parity_enable_bit_i && parity_type_select_i == upb_pkg::PAR_ODD |=> ^(tx_shift_q & upb_pkg::upb_mask(tx_slots_q))) // RULE14
		else $error("odd parity frame has even ones");
	chk_no_par: assert property (tx_state_q == upb_pkg::TX_IDLE && tx_tick && hold_vld_q && en && !parity_enable_bit_i |=> tx_shift_q[7:0] == $past(hold_data_q)) // RULE1
		else $error("data altered without parity");
	chk_rx_ninth: assert property (rx_done && word_length_select_i && !parity_enable_bit_i |=> received_ninth_bit_o == $past(rx_shift_q[8]) && rx_valid_o) // RULE7
		else $error("ninth received bit not stored");
	chk_rx_bit7: assert property (rx_valid_o && !word_length_select_i && parity_enable_bit_i |-> rx_data_o[7] == 1'b0) // RULE11
		else $error("parity stored in data bit seven");
	chk_parity_error_flag_set: assert property (rx_done && en && parity_enable_bit_i && rx_par_got != rx_par_exp |=> parity_error_flag_o) // RULE12
		else $error("parity error not flagged");

	cov_break:   cover property (tx_state_q == upb_pkg::TX_BREAK ##1 tx_state_q == upb_pkg::TX_IDLE);
	cov_nine:    cover property (rx_done && word_length_select_i);
	cov_parity_error_flag:    cover property ($rose(parity_error_flag_o));
	cov_tx_word: cover property (tx_state_q == upb_pkg::TX_STOP && tx_tick);
endmodule // upb_uart

// *** testbench/upb_remote.sv ***
// remote serial transceiver model: sends frames to the block, samples its line
// assumes DIV matches the block and both lines idle at the high mark level
`timescale 1ns/1ns
module upb_remote #(
	parameter int unsigned DIV = 8  // clocks per bit
) (
	input  wire logic clk_i,       // system clock
	input  wire logic line_in_i,   // block transmit line
	output logic      line_out_o   // block receive line
);
	int unsigned low_cnt  = 0;  // current low run, in clocks
	int unsigned last_low = 0;  // length of the last finished low run

	initial line_out_o = 1'b1;  // idle mark level

	// measure low runs of the block's line, used for break length
	always @(posedge clk_i) begin
		if (line_in_i === 1'b0) begin
			low_cnt <= low_cnt + 1;
		end else begin
			if (low_cnt != 0) begin
				last_low <= low_cnt;
			end
			low_cnt <= 0;
		end
	end

	// one frame: start, n slots lsb first, one stop, then idle high
	task automatic send(input logic [8:0] slots, input int n);
		@(negedge clk_i);
		line_out_o = 1'b0;
		repeat (DIV) @(negedge clk_i);
		for (int i = 0; i < n; i++) begin
			line_out_o = slots[i];
			repeat (DIV) @(negedge clk_i);
		end
		line_out_o = 1'b1;
		repeat (DIV) @(negedge clk_i);
	endtask

	// sample one frame of the block at bit centres
	task automatic grab(input int n, output logic [8:0] slots, output logic stop);
		slots = 9'h000;
		@(negedge line_in_i);
		repeat (DIV / 2) @(posedge clk_i);
		for (int i = 0; i < n; i++) begin
			repeat (DIV) @(posedge clk_i);
			slots[i] = line_in_i;
		end
		repeat (DIV) @(posedge clk_i);
		stop = line_in_i;
	endtask
endmodule // upb_remote

// *** testbench/tb.sv ***
// self-checking bench of the parity, break and ninth-bit serial block
// assumes a remote model on the lines and a shortened bit period
`timescale 1ns/1ns
module tb;
	localparam int unsigned DIV = 8;  // short bit period for simulation
	logic       clk_i = 1'b0, reset_i = 1'b1, en = 1'b1, wl = 1'b0, pe = 1'b0;
	logic [1:0] ty = 2'h0;             // parity type
	logic       brk_wr = 1'b0, brk_d = 1'b0, tx_valid_i = 1'b0, nb_i = 1'b0;
	logic [7:0] tx_data_i = 8'h00;
	logic       parity_error_flag_clr = 1'b0, tx_ready_o, tx_idle, serial_tx, serial_rx;
	logic       brk_o, rx_valid, rx_nb, parity_error_flag;
	logic [7:0] rx_data;
	logic [8:0] sl, s;                 // captured and expected slots
	logic       stp, exp_nb;           // stop level, expected ninth bit
	int         bad_count = 0, tests_run = 0, cyc = 0, rx_cnt = 0;
	int         exp_rx = 0;            // frames sent to the block so far

	always #20 clk_i = ~clk_i;  // 25 MHz

	upb_uart #(.DIV(DIV)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
		.serial_unit_enable_i(en), .word_length_select_i(wl), .parity_enable_bit_i(pe),
		.parity_type_select_i(ty), .break_wr_i(brk_wr), .break_wdata_i(brk_d),
		.break_send_bit_o(brk_o), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
		.transmit_ninth_bit_i(nb_i), .tx_ready_o(tx_ready_o), .tx_idle_o(tx_idle),
		.serial_tx_o(serial_tx), .serial_rx_i(serial_rx), .rx_valid_o(rx_valid),
		.rx_data_o(rx_data), .received_ninth_bit_o(rx_nb),
		.parity_error_flag_o(parity_error_flag), .parity_error_flag_clear_i(parity_error_flag_clr));
	upb_remote #(.DIV(DIV)) u_rem (.clk_i(clk_i), .line_in_i(serial_tx),
		.line_out_o(serial_rx));

	// count receive pulses and cut a hang short
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (rx_valid === 1'b1) begin
			rx_cnt <= rx_cnt + 1;
		end
		if (cyc == 30000) begin
			bad_count++;
			results();
		end
	end

	// compare one value and count it
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// closing report and verdict
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// expected slot pattern of a frame
	function automatic logic [8:0] frame(input logic [7:0] d, input logic n9,
		input logic w, input logic p, input logic [1:0] t);
		logic [8:0] f;
		logic       par;
		int         n;
		n = w ? 9 : 8;
		f = w ? {n9, d} : {1'b0, d};
		par = 1'b0;
		for (int i = 0; i < n - 1; i++) par ^= f[i];
		if (p) begin
			case (t)
				2'h0: f[n-1] = par;   // even total
				2'h1: f[n-1] = ~par;  // odd total
				2'h2: f[n-1] = 1'b1;  // forced one
				default: f[n-1] = 1'b0;  // forced zero
			endcase
		end
		return f;
	endfunction

	// hand one word to the transmit buffer
	task automatic offer(input logic [7:0] d, input logic n9);
		int w;
		w = 0;
		while (tx_ready_o !== 1'b1 && w < 500) begin
			@(negedge clk_i);
			w++;
		end
		tx_data_i = d;
		nb_i = n9;
		tx_valid_i = 1'b1;
		@(negedge clk_i);
		tx_valid_i = 1'b0;
	endtask

	// single-cycle pulse of the break write strobe
	task automatic brk(input logic v);
		brk_d = v;
		brk_wr = 1'b1;
		@(negedge clk_i);
		brk_wr = 1'b0;
		@(negedge clk_i);
	endtask

	initial begin
		repeat (2) @(negedge clk_i);
		reset_i = 1'b0;
		check("idle line", serial_tx, 1'b1);
		check("break bit", brk_o, 1'b0);
		// every word length, parity enable and parity type on transmit
		for (int c = 0; c < 16; c++) begin
			{wl, pe, ty} = 4'(c);
			offer(8'ha5 + 8'(c), c[0]);
			u_rem.grab(wl ? 9 : 8, sl, stp);
			check("tx slots", sl, frame(8'ha5 + 8'(c), c[0], wl, pe, ty));
			check("tx stop", stp, 1'b1);
			repeat (DIV) @(negedge clk_i);
		end
		// same set on receive, with a bad parity slot where parity is on
		exp_nb = 1'b0;
		for (int c = 0; c < 16; c++) begin
			{wl, pe, ty} = 4'(c);
			s = frame(8'hc3 ^ 8'(c), ~c[0], wl, pe, ty);
			u_rem.send(s, wl ? 9 : 8);
			exp_rx++;
			repeat (2) @(negedge clk_i);
			if (wl && !pe) exp_nb = ~c[0];
			check("rx count", 9'(rx_cnt), 9'(exp_rx));
			check("rx data", rx_data, (pe && !wl) ? (8'hc3 ^ 8'(c)) & 8'h7f : 8'hc3 ^ 8'(c));
			check("rx ninth", rx_nb, exp_nb);
			check("parity_error_flag clean", parity_error_flag, 1'b0);
			if (pe) begin
				s[wl ? 8 : 7] = ~s[wl ? 8 : 7];
				u_rem.send(s, wl ? 9 : 8);
				exp_rx++;
				repeat (2) @(negedge clk_i);
				check("parity_error_flag set", parity_error_flag, 1'b1);
				parity_error_flag_clr = 1'b1;
				@(negedge clk_i);
				parity_error_flag_clr = 1'b0;
				@(negedge clk_i);
				check("parity_error_flag clear", parity_error_flag, 1'b0);
			end
		end
		// break behind a buffered word, cleared early
		{wl, pe, ty} = 4'h0;
		offer(8'h3c, 1'b0);
		check("tx ready busy", tx_ready_o, 1'b0);
		// the start bit may fall while the strobe is pulsed, so watch meanwhile
		fork
			u_rem.grab(8, sl, stp);
			brk(1'b1);
		join
		check("break set", brk_o, 1'b1);
		check("word first", sl, frame(8'h3c, 1'b0, 1'b0, 1'b0, 2'h0));
		repeat (4 * DIV) @(negedge clk_i);
		check("break low", serial_tx, 1'b0);
		check("tx busy", tx_idle, 1'b0);
		brk(1'b0);
		repeat (18 * DIV) @(negedge clk_i);
		check("break len", 9'(u_rem.last_low >= 13 * DIV && u_rem.last_low <= 14 * DIV), 9'h001);
		check("line back", serial_tx, 1'b1);
		check("tx idle", tx_idle, 1'b1);
		// unit disable clears the break bit
		brk(1'b1);
		en = 1'b0;
		repeat (2) @(negedge clk_i);
		check("break off", brk_o, 1'b0);
		check("line off", serial_tx, 1'b1);
		en = 1'b1;
		repeat (2) @(negedge clk_i);
		results();
	end
endmodule // tb
